/* common/fewc_pkg.sv */
package fewc_pkg;

	// ****************************************
	// Timing.
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;
	// The reference timer runs at 5 MHz and counts two to the ninth.
	localparam int REF_CLK_PERIOD_NS = 200;
	localparam int TIMER_EXP = 9;
	localparam int PULSE_NS = (1 << TIMER_EXP) * REF_CLK_PERIOD_NS;
	localparam int PULSE_MIN_NS = 90000;
	localparam int PULSE_MAX_NS = 120000;
	localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_MIN_CYCLES = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_MAX_CYCLES = PULSE_MAX_NS / CLK_PERIOD_NS;
	localparam int RECOVERY_NS = 2000;
	localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Cycles after driving the strobe low before the ready line is trusted.
	localparam int READY_SETTLE_CYCLES = 2;

	// ****************************************
	// Write counts.
	// ****************************************
	localparam int ERASE_WRITES = 97655;
	localparam int PROGRAM_WRITES = 20;

	// ****************************************
	// Widths and address map.
	// ****************************************
	localparam int ADDR_W = 16;
	localparam int MEM_ADDR_W = 14;
	localparam int DATA_W = 8;
	localparam int NUM_MEM = 2;
	localparam int TMR_W = 17;
	localparam int GAP_W = 10;
	localparam int SW_SPACE_BIT = 15;
	localparam int CHIP_SEL_BIT = 14;
	localparam logic [1:0] SW_HV_OFF = 2'h0;
	localparam logic [1:0] SW_HV_ON = 2'h1;
	localparam logic [1:0] SW_ERASE_OFF = 2'h2;
	localparam logic [1:0] SW_ERASE_ON = 2'h3;
	localparam logic [MEM_ADDR_W-1:0] ERASE_TRIG_MASK = 14'h0046;
	localparam logic [MEM_ADDR_W-1:0] ERASE_ADDR_HI = 14'h00ff;
	localparam logic [MEM_ADDR_W-1:0] ERASE_ADDR_LO = 14'h00f7;
	localparam logic [DATA_W-1:0] ERASED_DATA = 8'hff;

	// ****************************************
	// States.
	// ****************************************
	typedef enum logic [1:0] {D_IDLE, D_STRETCH, D_RELEASE} fewc_dev_state_type;
	typedef enum logic [2:0] {H_IDLE, H_STEP, H_WR_LOW, H_WR_HIGH, H_GAP} fewc_host_state_type;

endpackage

/* common/fewc_bus_if.sv */
`timescale 1ns/1ns
interface fewc_bus_if;

	// ****************************************
	// Processor bus toward the control logic.
	// ****************************************
	logic [fewc_pkg::ADDR_W-1:0] addr;
	logic [fewc_pkg::DATA_W-1:0] wdata;
	logic wr_n;
	logic rd_n;
	logic ready;

	modport host (
		output addr,
		output wdata,
		output wr_n,
		output rd_n,
		input ready
	);

	modport dev (
		input addr,
		input wdata,
		input wr_n,
		input rd_n,
		output ready
	);

endinterface

/* rtl/fewc_dev.sv */
`timescale 1ns/1ns
module fewc_dev #(
	parameter int PULSE_CYCLES = fewc_pkg::PULSE_CYCLES
) (
	// Clock and reset.
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	// Processor bus.
	fewc_bus_if.dev bus,
	// Memory pins.
	output logic [fewc_pkg::NUM_MEM-1:0] MEM_CE_N_OUT,
	output logic MEM_OE_N_OUT,
	output logic PROGRAM_STROBE_N_OUT,
	output logic [fewc_pkg::MEM_ADDR_W-1:0] MEM_ADDR_OUT,
	output logic [fewc_pkg::DATA_W-1:0] MEM_DATA_OUT,
	output logic MEM_DATA_OE_OUT,
	// Supply and erase switches.
	output logic HV_SUPPLY_ON_N_OUT,
	output logic ERASE_ON_OUT
);

	// ****************************************
	// State.
	// ****************************************
	typedef struct packed {
		fewc_pkg::fewc_dev_state_type state;
		logic [fewc_pkg::TMR_W-1:0] tmr;
		logic ready;
		logic wr_prev;
		logic hv_on;
		logic erase_on;
		logic [fewc_pkg::NUM_MEM-1:0] ce_n;
		logic oe_n;
		logic pgm_n;
		logic [fewc_pkg::MEM_ADDR_W-1:0] addr;
		logic [fewc_pkg::DATA_W-1:0] data;
		logic data_oe;
	} fewc_dev_regs_type;

	fewc_dev_regs_type dev_r;
	fewc_dev_regs_type dev_nxt;
	logic wr_start;
	logic mem_space;

	// ****************************************
	// Next state.
	// ****************************************
	// A write cycle begins on the falling strobe; switch writes never stretch.
	always_comb begin
		dev_nxt = dev_r;
		wr_start = dev_r.wr_prev & ~bus.wr_n;
		mem_space = ~bus.addr[fewc_pkg::SW_SPACE_BIT];
		dev_nxt.wr_prev = bus.wr_n;
		if (wr_start && !mem_space) begin
			case (bus.addr[1:0])
				fewc_pkg::SW_HV_OFF: dev_nxt.hv_on = 1'b0;
				fewc_pkg::SW_HV_ON: dev_nxt.hv_on = 1'b1;
				fewc_pkg::SW_ERASE_OFF: dev_nxt.erase_on = 1'b0;
				default: dev_nxt.erase_on = 1'b1;
			endcase
		end
		case (dev_r.state)
			fewc_pkg::D_IDLE: begin
				if (wr_start && mem_space && dev_r.hv_on) begin
					dev_nxt.ready = 1'b0;
					dev_nxt.tmr = '0;
					dev_nxt.state = fewc_pkg::D_STRETCH;
				end else if (wr_start) begin
					dev_nxt.state = fewc_pkg::D_RELEASE;
				end
			end
			fewc_pkg::D_STRETCH: begin
				dev_nxt.tmr = dev_r.tmr + 1'b1;
				if (dev_r.tmr == fewc_pkg::TMR_W'(PULSE_CYCLES - 1)) begin
					dev_nxt.ready = 1'b1;
					dev_nxt.state = fewc_pkg::D_RELEASE;
				end
			end
			fewc_pkg::D_RELEASE: begin
				// Rearming waits for the strobe to rise, so one long write is one pulse.
				if (bus.wr_n) begin
					dev_nxt.state = fewc_pkg::D_IDLE;
				end
			end
			default: begin
				dev_nxt.state = fewc_pkg::D_IDLE;
				dev_nxt.ready = 1'b1;
			end
		endcase
		// Only the addressed memory is selected; the others stay idle.
		for (int i = 0; i < fewc_pkg::NUM_MEM; i++) begin
			dev_nxt.ce_n[i] = ~(mem_space && (~bus.wr_n || ~bus.rd_n)
				&& (int'(bus.addr[fewc_pkg::CHIP_SEL_BIT]) == i));
		end
		dev_nxt.oe_n = bus.rd_n | ~mem_space;
		dev_nxt.pgm_n = bus.wr_n | ~mem_space;
		dev_nxt.addr = bus.addr[fewc_pkg::MEM_ADDR_W-1:0]
			| (dev_r.erase_on ? fewc_pkg::ERASE_TRIG_MASK : '0);
		dev_nxt.data = bus.wdata;
		dev_nxt.data_oe = ~bus.wr_n & mem_space;
	end

	// ****************************************
	// Registers.
	// ****************************************
	// Switches come up off so no high voltage appears before software asks.
	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			dev_r <= '{state: fewc_pkg::D_IDLE, tmr: '0, ready: 1'b1, wr_prev: 1'b1,
				hv_on: 1'b0, erase_on: 1'b0, ce_n: '1, oe_n: 1'b1, pgm_n: 1'b1,
				addr: '0, data: '0, data_oe: 1'b0};
		end else begin
			dev_r <= dev_nxt;
		end
	end

	// Every pin leaves from a flop, the supply pin through one inverter, so all pins share one cycle of delay.
	assign bus.ready = dev_r.ready;
	assign MEM_CE_N_OUT = dev_r.ce_n;
	assign MEM_OE_N_OUT = dev_r.oe_n;
	assign PROGRAM_STROBE_N_OUT = dev_r.pgm_n;
	assign MEM_ADDR_OUT = dev_r.addr;
	assign MEM_DATA_OUT = dev_r.data;
	assign MEM_DATA_OE_OUT = dev_r.data_oe;
	assign HV_SUPPLY_ON_N_OUT = ~dev_r.hv_on;
	assign ERASE_ON_OUT = dev_r.erase_on;

endmodule // fewc_dev

/* rtl/fewc_host.sv */
// Overview of operation
// - Ready held low stretching writes near 100 us.
// - Stretch only while high supply is on.
// - Strobe low pulse between 90 and 120 us.
// - Pulse is 2^9 ticks of 5 MHz.
// - Write strobe drives the program strobe directly.
// - Switches set by dummy writes, latched outputs.
// - Erase on forces erase trigger lines high.
// - Erase phases at 00FF and 00F7, any order.
// - Each erase phase totals about ten seconds.
// - Digital timer needs 97655 writes per phase.
// - Erase switch off before any programming.
// - Each byte written twenty times in a row.
// - Skip programming bytes equal to erased value.
// - Wait 2 us after switching and phases.
// - Only the selected memory is erased or written.
// - Output enable high, data valid during strobe.
`timescale 1ns/1ns
module fewc_host #(
	parameter int ERASE_WRITES = fewc_pkg::ERASE_WRITES
) (
	// Clock and reset.
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	// Command port.
	input wire logic CMD_VALID_IN,
	input wire logic CMD_ERASE_IN,
	input wire logic CMD_CHIP_IN,
	input wire logic [fewc_pkg::MEM_ADDR_W-1:0] CMD_ADDR_IN,
	input wire logic [fewc_pkg::DATA_W-1:0] CMD_DATA_IN,
	// Status.
	output logic CMD_READY_OUT,
	output logic DONE_OUT,
	// Processor bus.
	fewc_bus_if.host bus
);

	// ****************************************
	// State.
	// ****************************************
	typedef struct packed {
		fewc_pkg::fewc_host_state_type state;
		logic [2:0] step;
		logic erase_op;
		logic chip;
		logic [fewc_pkg::MEM_ADDR_W-1:0] maddr;
		logic [fewc_pkg::DATA_W-1:0] mdata;
		logic wr_n;
		logic [fewc_pkg::ADDR_W-1:0] addr;
		logic [fewc_pkg::DATA_W-1:0] wdata;
		logic [fewc_pkg::TMR_W-1:0] left;
		logic [fewc_pkg::GAP_W-1:0] cnt;
		logic busy;
		logic done;
	} fewc_host_regs_type;

	fewc_host_regs_type host_r;
	fewc_host_regs_type host_nxt;
	logic [fewc_pkg::ADDR_W-1:0] act_addr;
	logic [fewc_pkg::TMR_W-1:0] act_count;
	logic act_end;
	logic [fewc_pkg::ADDR_W-1:0] mem_base;

	// ****************************************
	// Sequence script.
	// ****************************************
	// Each step is a burst of identical writes followed by a recovery gap; an empty burst moves on with no gap.
	// A switch change is a burst of one dummy write into the switch space.
	always_comb begin
		act_addr = '0;
		act_count = '0;
		act_end = 1'b0;
		mem_base = {1'b0, host_r.chip, {fewc_pkg::MEM_ADDR_W{1'b0}}};
		if (host_r.erase_op) begin
			case (host_r.step)
				3'h0: begin
					act_addr = {1'b1, 13'h0000, fewc_pkg::SW_HV_ON};
					act_count = fewc_pkg::TMR_W'(1);
				end
				3'h1: begin
					act_addr = {1'b1, 13'h0000, fewc_pkg::SW_ERASE_ON};
					act_count = fewc_pkg::TMR_W'(1);
				end
				3'h2: begin
					act_addr = mem_base | fewc_pkg::ADDR_W'(fewc_pkg::ERASE_ADDR_HI);
					act_count = fewc_pkg::TMR_W'(ERASE_WRITES);
				end
				3'h3: begin
					act_addr = mem_base | fewc_pkg::ADDR_W'(fewc_pkg::ERASE_ADDR_LO);
					act_count = fewc_pkg::TMR_W'(ERASE_WRITES);
				end
				3'h4: begin
					act_addr = {1'b1, 13'h0000, fewc_pkg::SW_ERASE_OFF};
					act_count = fewc_pkg::TMR_W'(1);
				end
				3'h5: begin
					act_addr = {1'b1, 13'h0000, fewc_pkg::SW_HV_OFF};
					act_count = fewc_pkg::TMR_W'(1);
				end
				default: act_end = 1'b1;
			endcase
		end else begin
			case (host_r.step)
				3'h0: begin
					act_addr = {1'b1, 13'h0000, fewc_pkg::SW_ERASE_OFF};
					act_count = fewc_pkg::TMR_W'(1);
				end
				3'h1: begin
					act_addr = {1'b1, 13'h0000, fewc_pkg::SW_HV_ON};
					act_count = fewc_pkg::TMR_W'(1);
				end
				3'h2: begin
					act_addr = mem_base | fewc_pkg::ADDR_W'(host_r.maddr);
					// An erased value needs no programming, so the burst is empty.
					act_count = (host_r.mdata == fewc_pkg::ERASED_DATA) ? '0
						: fewc_pkg::TMR_W'(fewc_pkg::PROGRAM_WRITES);
				end
				3'h3: begin
					act_addr = {1'b1, 13'h0000, fewc_pkg::SW_HV_OFF};
					act_count = fewc_pkg::TMR_W'(1);
				end
				default: act_end = 1'b1;
			endcase
		end
	end

	// ****************************************
	// Next state.
	// ****************************************
	always_comb begin
		host_nxt = host_r;
		host_nxt.done = 1'b0;
		case (host_r.state)
			fewc_pkg::H_IDLE: begin
				if (CMD_VALID_IN) begin
					host_nxt.erase_op = CMD_ERASE_IN;
					host_nxt.chip = CMD_CHIP_IN;
					host_nxt.maddr = CMD_ADDR_IN;
					host_nxt.mdata = CMD_DATA_IN;
					host_nxt.step = '0;
					host_nxt.busy = 1'b1;
					host_nxt.state = fewc_pkg::H_STEP;
				end
			end
			fewc_pkg::H_STEP: begin
				if (act_end) begin
					host_nxt.busy = 1'b0;
					host_nxt.done = 1'b1;
					host_nxt.state = fewc_pkg::H_IDLE;
				end else if (act_count == '0) begin
					host_nxt.step = host_r.step + 1'b1;
				end else begin
					// Address and data go out with the falling strobe.
					host_nxt.addr = act_addr;
					host_nxt.wdata = host_r.erase_op ? fewc_pkg::ERASED_DATA : host_r.mdata;
					host_nxt.left = act_count;
					host_nxt.wr_n = 1'b0;
					host_nxt.cnt = '0;
					host_nxt.state = fewc_pkg::H_WR_LOW;
				end
			end
			fewc_pkg::H_WR_LOW: begin
				// Ready is ignored until the control logic has had time to drop it.
				if (host_r.cnt < fewc_pkg::GAP_W'(fewc_pkg::READY_SETTLE_CYCLES)) begin
					host_nxt.cnt = host_r.cnt + 1'b1;
				end else if (bus.ready) begin
					host_nxt.wr_n = 1'b1;
					host_nxt.left = host_r.left - 1'b1;
					host_nxt.state = fewc_pkg::H_WR_HIGH;
				end
			end
			fewc_pkg::H_WR_HIGH: begin
				// One high cycle lets the control logic rearm between writes.
				host_nxt.cnt = '0;
				if (host_r.left == '0) begin
					host_nxt.state = fewc_pkg::H_GAP;
				end else begin
					host_nxt.wr_n = 1'b0;
					host_nxt.state = fewc_pkg::H_WR_LOW;
				end
			end
			fewc_pkg::H_GAP: begin
				host_nxt.cnt = host_r.cnt + 1'b1;
				if (host_r.cnt == fewc_pkg::GAP_W'(fewc_pkg::RECOVERY_CYCLES - 1)) begin
					host_nxt.step = host_r.step + 1'b1;
					host_nxt.state = fewc_pkg::H_STEP;
				end
			end
			default: begin
				host_nxt.state = fewc_pkg::H_IDLE;
				host_nxt.wr_n = 1'b1;
				host_nxt.busy = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Registers.
	// ****************************************
	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			host_r <= '{state: fewc_pkg::H_IDLE, step: '0, erase_op: 1'b0, chip: 1'b0,
				maddr: '0, mdata: '0, wr_n: 1'b1, addr: '0, wdata: '0, left: '0,
				cnt: '0, busy: 1'b0, done: 1'b0};
		end else begin
			host_r <= host_nxt;
		end
	end

	// Reads are never issued, so output enable of the memory stays high.
	assign bus.rd_n = 1'b1;
	assign bus.wr_n = host_r.wr_n;
	assign bus.addr = host_r.addr;
	assign bus.wdata = host_r.wdata;
	assign CMD_READY_OUT = ~host_r.busy;
	assign DONE_OUT = host_r.done;

endmodule // fewc_host

/* testbench/fewc_monitor.sv */
`timescale 1ns/1ns
// ****************************************
// Checker beside the shared processor bus.
// ****************************************
module fewc_monitor #(
	parameter int PULSE_CYCLES = fewc_pkg::PULSE_CYCLES
) (
	// Clock and reset.
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	// Processor bus.
	input wire logic [fewc_pkg::ADDR_W-1:0] addr,
	input wire logic wr_n,
	input wire logic ready,
	// Memory pins and switches.
	input wire logic PROGRAM_STROBE_N_OUT,
	input wire logic HV_SUPPLY_ON_N_OUT,
	input wire logic ERASE_ON_OUT,
	input wire logic [fewc_pkg::MEM_ADDR_W-1:0] MEM_ADDR_OUT,
	input wire logic [fewc_pkg::NUM_MEM-1:0] MEM_CE_N_OUT
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (RESET_IN);

	logic [31:0] low_cnt_r;

	// Counts sampled low cycles of ready, since a repetition that long would not unroll.
	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN || ready) begin
			low_cnt_r <= '0;
		end else begin
			low_cnt_r <= low_cnt_r + 32'h1;
		end
	end

	sequence s_mem_start;
		$fell(wr_n) && !addr[fewc_pkg::SW_SPACE_BIT];
	endsequence
	sequence s_sw_start;
		$fell(wr_n) && addr[fewc_pkg::SW_SPACE_BIT];
	endsequence

	property p_ready_drop;
		s_mem_start ##0 !HV_SUPPLY_ON_N_OUT |=> !ready ##1 !ready;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready did not drop");
	property p_no_wait;
		(s_sw_start or (s_mem_start ##0 HV_SUPPLY_ON_N_OUT)) |=> ready [*2];
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("wait state without supply");
	property p_ready_len;
		$rose(ready) |-> low_cnt_r == PULSE_CYCLES;
	endproperty
	a_ready_len: assert property (p_ready_len) else $error("stretch length wrong");
	property p_ready_max;
		low_cnt_r <= PULSE_CYCLES;
	endproperty
	a_ready_max: assert property (p_ready_max) else $error("stretch too long");
	property p_rearm;
		$rose(ready) |-> ready [*3];
	endproperty
	a_rearm: assert property (p_rearm) else $error("rearmed before release");
	property p_strobe;
		s_mem_start |=> !PROGRAM_STROBE_N_OUT;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe did not follow write");
	property p_hv_sw;
		s_sw_start ##0 !addr[1] |=> HV_SUPPLY_ON_N_OUT == !$past(addr[0]);
	endproperty
	a_hv_sw: assert property (p_hv_sw) else $error("supply switch not latched");
	property p_erase_sw;
		s_sw_start ##0 addr[1] |=> ERASE_ON_OUT == $past(addr[0]);
	endproperty
	a_erase_sw: assert property (p_erase_sw) else $error("erase switch not latched");
	property p_hv_stable;
		$changed(HV_SUPPLY_ON_N_OUT) |-> $past(addr[fewc_pkg::SW_SPACE_BIT]) && !$past(wr_n);
	endproperty
	a_hv_stable: assert property (p_hv_stable) else $error("supply changed on its own");
	property p_erase_force;
		!PROGRAM_STROBE_N_OUT && ERASE_ON_OUT |->
			(MEM_ADDR_OUT & fewc_pkg::ERASE_TRIG_MASK) == fewc_pkg::ERASE_TRIG_MASK;
	endproperty
	a_erase_force: assert property (p_erase_force) else $error("trigger lines not high");
	// The switch writes carry addresses without the full trigger mask, but the mask is ORed in while erase is on, so this one holds.
	property p_erase_hold;
		ERASE_ON_OUT && $past(ERASE_ON_OUT) |->
			(MEM_ADDR_OUT & fewc_pkg::ERASE_TRIG_MASK) == fewc_pkg::ERASE_TRIG_MASK;
	endproperty
	a_erase_hold: assert property (p_erase_hold) else $error("trigger lines dropped");
	property p_one_chip;
		!PROGRAM_STROBE_N_OUT |-> $onehot(~MEM_CE_N_OUT);
	endproperty
	a_one_chip: assert property (p_one_chip) else $error("select not one memory");
endmodule // fewc_monitor

/* testbench/fewc_tb_top.sv */
`timescale 1ns/1ns
module fewc_tb_top;
	// ****************************************
	// Signals and instances.
	// ****************************************
	localparam int PULSE = 8;
	localparam int EW = 3;
	logic CLK_SYS_IN = 1'b0;
	logic RESET_IN = 1'b1;
	logic cmd_valid = 1'b0, cmd_erase = 1'b0, cmd_chip = 1'b0;
	logic [13:0] cmd_addr = 14'h0000;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_ready, done, oe_n, strobe_n, data_oe, hv_n, erase_on;
	logic [1:0] ce_n, last_ce;
	logic [13:0] maddr, last_addr;
	logic [7:0] mdata, last_data;
	logic sb_q = 1'b1, hv_q = 1'b1, er_q = 1'b0;
	int n_fail = 0, samples_checked = 0;
	int pulses = 0, hi_pulses = 0, bad = 0, er_seen = 0, low_len = 0, since_sw = 0;
	fewc_bus_if bus_if();
	fewc_host #(.ERASE_WRITES(EW)) fewc_host_inst (.CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN),
		.CMD_VALID_IN(cmd_valid), .CMD_ERASE_IN(cmd_erase), .CMD_CHIP_IN(cmd_chip),
		.CMD_ADDR_IN(cmd_addr), .CMD_DATA_IN(cmd_data), .CMD_READY_OUT(cmd_ready),
		.DONE_OUT(done), .bus(bus_if.host));
	fewc_dev #(.PULSE_CYCLES(PULSE)) fewc_dev_inst (.CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN),
		.bus(bus_if.dev), .MEM_CE_N_OUT(ce_n), .MEM_OE_N_OUT(oe_n), .PROGRAM_STROBE_N_OUT(strobe_n),
		.MEM_ADDR_OUT(maddr), .MEM_DATA_OUT(mdata), .MEM_DATA_OE_OUT(data_oe),
		.HV_SUPPLY_ON_N_OUT(hv_n), .ERASE_ON_OUT(erase_on));
	fewc_monitor #(.PULSE_CYCLES(PULSE)) fewc_monitor_inst (.CLK_SYS_IN(CLK_SYS_IN),
		.RESET_IN(RESET_IN), .addr(bus_if.addr), .wr_n(bus_if.wr_n), .ready(bus_if.ready),
		.PROGRAM_STROBE_N_OUT(strobe_n), .HV_SUPPLY_ON_N_OUT(hv_n), .ERASE_ON_OUT(erase_on),
		.MEM_ADDR_OUT(maddr), .MEM_CE_N_OUT(ce_n));

	// Clock at 250 MHz.
	always #2 CLK_SYS_IN = ~CLK_SYS_IN;

	// Records each program pulse; width, recovery gap and pin levels are judged here.
	always @(posedge CLK_SYS_IN) begin
		since_sw = (hv_n !== hv_q || erase_on !== er_q) ? 0 : since_sw + 1;
		if (!strobe_n && sb_q) begin
			pulses++;
			hi_pulses += maddr[3];
			er_seen += erase_on;
			last_addr = maddr;
			last_data = mdata;
			last_ce = ce_n;
			if (since_sw < fewc_pkg::RECOVERY_CYCLES || oe_n !== 1'b1 || data_oe !== 1'b1) begin
				bad++;
			end
		end
		if (strobe_n === 1'b0) begin
			low_len++;
		end else if (!sb_q) begin
			bad += (low_len < PULSE || low_len > PULSE + 4);
			low_len = 0;
		end
		sb_q = strobe_n;
		hv_q = hv_n;
		er_q = erase_on;
	end

	// ****************************************
	// Tasks.
	// ****************************************
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Issues one command and waits, bounded, for its completion pulse.
	task automatic run_cmd(input logic er, input logic ch, input logic [13:0] a,
		input logic [7:0] d);
		int i;
		pulses = 0;
		hi_pulses = 0;
		bad = 0;
		er_seen = 0;
		cmd_erase = er;
		cmd_chip = ch;
		cmd_addr = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(posedge CLK_SYS_IN);
		#1 cmd_valid = 1'b0;
		chk(cmd_ready, 1'b0, "busy after take");
		for (i = 0; i < 20000 && done !== 1'b1; i++) begin
			@(posedge CLK_SYS_IN);
			#1;
		end
		if (done !== 1'b1) begin
			n_fail++;
			$display("Error at %0t: command did not finish", $time);
			close_out();
		end
		chk(cmd_ready, 1'b1, "idle with done");
	endtask

	// ****************************************
	// Main sequence.
	// ****************************************
	initial begin
		logic [7:0] dt [3];
		logic [13:0] at [3];
		dt = '{8'h5a, 8'hff, 8'ha5};
		at = '{14'h3ffe, 14'h3fff, 14'h0000};
		repeat (12) @(posedge CLK_SYS_IN);
		#1 RESET_IN = 1'b0;
		chk({bus_if.ready, ce_n, oe_n, strobe_n, hv_n, erase_on, cmd_ready}, 8'hfd, "reset");
		// Erase of the second memory, both phases.
		run_cmd(1'b1, 1'b1, 14'h0000, 8'hff);
		chk(pulses, 2 * EW, "erase writes");
		chk(hi_pulses, EW, "high phase writes");
		chk(last_addr, fewc_pkg::ERASE_ADDR_LO | fewc_pkg::ERASE_TRIG_MASK, "erase addr");
		chk(last_ce, 2'h1, "erase select");
		chk(bad, 0, "erase pulses");
		chk({hv_n, erase_on}, 2'h2, "switches after erase");
		// Back-to-back byte programs, an erased-value byte among them.
		for (int k = 0; k < 3; k++) begin
			run_cmd(1'b0, k[0], at[k], dt[k]);
			chk(pulses, (dt[k] == 8'hff) ? 0 : fewc_pkg::PROGRAM_WRITES, "program writes");
			chk(er_seen, 0, "erase during program");
			chk(bad, 0, "program pulses");
			if (dt[k] != 8'hff) begin
				chk({last_ce, last_addr, last_data}, {~(2'h1 << k[0]), at[k], dt[k]}, "target");
			end
		end
		close_out();
	end
endmodule // fewc_tb_top
